// ---- cdd_pkg.sv ----
// shared constants and carrier types for the clock-domain distribution block
package cdd_pkg;

  // ring-oscillator master clock and crystal figures
  localparam real MASTER_CLK_MHZ = 64.52;
  localparam real SLOW_XTAL_KHZ  = 32.768;

  // divider widths and reset values
  localparam int          DIV_W           = 8;
  localparam logic [7:0]  CTRL_DIV_RESET  = 8'h01;
  localparam logic [7:0]  HOST_DIV_RESET  = 8'h01;

  // fixed-domain and host-domain divide ratios
  localparam int          FIX_CNT_W       = 10;
  localparam logic [9:0]  RATIO_2         = 10'h002;
  localparam logic [9:0]  RATIO_4         = 10'h004;
  localparam logic [9:0]  RATIO_8         = 10'h008;
  localparam logic [9:0]  RATIO_16        = 10'h010;
  localparam logic [9:0]  RATIO_32        = 10'h020;
  localparam logic [9:0]  RATIO_64        = 10'h040;
  localparam logic [9:0]  RATIO_128       = 10'h080;
  localparam logic [9:0]  RATIO_640       = 10'h280;
  localparam logic [9:0]  HOST_RATIO_64   = 10'h040;

  // synchroniser depth for the slow crystal clock
  localparam int          SYNC_STAGES     = 2;

  // fixed-domain enables travel together
  typedef struct packed {
    logic div640;
    logic div128;
    logic div64;
    logic div32;
    logic div16;
    logic div8;
    logic div4;
    logic div2;
  } cdd_fixed_ticks_t;

  // slow-domain fan-out, one copy per driven block
  typedef struct packed {
    logic ring_osc_raw;
    logic wdt_forced_reset;
    logic led_if;
    logic hib_timer1;
    logic hib_timer0;
    logic watchdog;
    logic week_timer;
  } cdd_slow_fanout_t;

endpackage : cdd_pkg

// ---- cdd_tick_div.sv ----
// one-cycle enable divider, pulse once every ratio cycles of the master clock
module cdd_tick_div #(
  parameter int W = 10
) (
  // clock and restart
  input  wire logic         core_clk,
  input  wire logic         restart,
  // control
  input  wire logic         run,
  input  wire logic [W-1:0] ratio,
  // output
  output logic              tick
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic         next_tick;

  always_comb
  begin
    next_count = count;
    next_tick  = 1'b0;
    if (restart || !run)
    begin
      // known phase: first pulse a full period after the start
      next_count = '0;
    end
    else if (count >= ratio - W'(1))
    begin
      next_count = '0;
      next_tick  = 1'b1;
    end
    else
    begin
      next_count = count + W'(1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    count <= next_count;
    tick  <= next_tick;
  end

endmodule : cdd_tick_div

// ---- cdd_clock_dist.sv ----
// clock-domain distribution: programmable, fixed, host and slow-domain enables
module cdd_clock_dist #(
  parameter int DIV_W = cdd_pkg::DIV_W
) (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  // oscillator and supply status
  input  wire logic                      ring_osc_run,
  input  wire logic                      runtime_supply_good,
  input  wire logic                      standby_supply_good,
  // divider settings held elsewhere
  input  wire logic [DIV_W-1:0]          controller_div,
  input  wire logic [DIV_W-1:0]          host_div,
  // raw crystal clock level
  input  wire logic                      slow_crystal_clock,
  // programmable domain
  output logic                           controller_bus_tick,
  output logic                           host_bus_tick,
  // fixed domain
  output cdd_pkg::cdd_fixed_ticks_t      master_ticks,
  // host domain
  output logic                           host_domain_div64_tick,
  // slow domain
  output logic                           slow_crystal_clock_synced,
  output cdd_pkg::cdd_slow_fanout_t      slow_fanout
);

  // restart pulse on oscillator start keeps divider phase known
  logic osc_run_q;
  logic next_osc_run_q;
  logic restart;
  logic run_fixed;
  logic run_host;

  always_comb
  begin
    next_osc_run_q = ring_osc_run;
    if (sys_rst)
    begin
      next_osc_run_q = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    osc_run_q <= next_osc_run_q;
  end

  assign restart   = sys_rst || (ring_osc_run && !osc_run_q);
  assign run_fixed = ring_osc_run;
  assign run_host  = ring_osc_run && runtime_supply_good;

  // zero divider value treated as divide by one
  function automatic logic [cdd_pkg::FIX_CNT_W-1:0] prog_ratio(input logic [DIV_W-1:0] d);
    logic [cdd_pkg::FIX_CNT_W-1:0] r;
    r = cdd_pkg::FIX_CNT_W'(d);
    if (d == '0)
    begin
      r = cdd_pkg::FIX_CNT_W'(1);
    end
    return r;
  endfunction : prog_ratio

  logic [9:0] ratios [0:10];
  logic       run_sel [0:10];
  logic [10:0] ticks_raw;

  always_comb
  begin
    ratios[0]  = prog_ratio(controller_div);
    ratios[1]  = prog_ratio(host_div);
    ratios[2]  = cdd_pkg::RATIO_2;
    ratios[3]  = cdd_pkg::RATIO_4;
    ratios[4]  = cdd_pkg::RATIO_8;
    ratios[5]  = cdd_pkg::RATIO_16;
    ratios[6]  = cdd_pkg::RATIO_32;
    ratios[7]  = cdd_pkg::RATIO_64;
    ratios[8]  = cdd_pkg::RATIO_128;
    ratios[9]  = cdd_pkg::RATIO_640;
    ratios[10] = cdd_pkg::HOST_RATIO_64;
    for (int i = 0; i < 11; i++)
    begin
      run_sel[i] = run_fixed;
    end
    run_sel[10] = run_host;
  end

  for (genvar g = 0; g < 11; g++)
  begin : g_div
    cdd_tick_div #(
      .W (cdd_pkg::FIX_CNT_W)
    ) u_div (
      .core_clk (core_clk),
      .restart  (restart),
      .run      (run_sel[g]),
      .ratio    (ratios[g]),
      .tick     (ticks_raw[g])
    );
  end

  // slow crystal synchroniser; first stage read only by the second
  logic [cdd_pkg::SYNC_STAGES-1:0] sync_q;
  logic [cdd_pkg::SYNC_STAGES-1:0] next_sync_q;
  logic                            bypass;
  logic                            next_slow_synced;
  cdd_pkg::cdd_slow_fanout_t       next_fanout;

  assign bypass = !ring_osc_run || !standby_supply_good;

  always_comb
  begin
    next_sync_q = {sync_q[cdd_pkg::SYNC_STAGES-2:0], slow_crystal_clock};
    // bypass passes the crystal level straight through; only sys_rst stops it, forcing the output low
    next_slow_synced = bypass ? slow_crystal_clock : sync_q[cdd_pkg::SYNC_STAGES-1];
    next_fanout = '{default: next_slow_synced};
    next_fanout.ring_osc_raw = slow_crystal_clock;
    if (sys_rst)
    begin
      next_sync_q = '0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    sync_q <= next_sync_q;
  end

  // output registers
  logic                      next_controller_bus_tick;
  logic                      next_host_bus_tick;
  cdd_pkg::cdd_fixed_ticks_t next_master_ticks;
  logic                      next_host_domain_div64_tick;
  logic                      next_slow_crystal_clock_synced;
  cdd_pkg::cdd_slow_fanout_t next_slow_fanout;

  always_comb
  begin
    next_controller_bus_tick       = ticks_raw[0] && run_fixed;
    next_host_bus_tick             = ticks_raw[1] && run_fixed;
    next_master_ticks              = ticks_raw[9:2] & {8{run_fixed}};
    next_host_domain_div64_tick    = ticks_raw[10] && run_host;
    next_slow_crystal_clock_synced = next_slow_synced;
    next_slow_fanout               = next_fanout;
    if (sys_rst)
    begin
      next_controller_bus_tick       = 1'b0;
      next_host_bus_tick             = 1'b0;
      next_master_ticks              = '0;
      next_host_domain_div64_tick    = 1'b0;
      next_slow_crystal_clock_synced = 1'b0;
      next_slow_fanout               = '0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    controller_bus_tick       <= next_controller_bus_tick;
    host_bus_tick             <= next_host_bus_tick;
    master_ticks              <= next_master_ticks;
    host_domain_div64_tick    <= next_host_domain_div64_tick;
    slow_crystal_clock_synced <= next_slow_crystal_clock_synced;
    slow_fanout               <= next_slow_fanout;
  end

  // checks
  logic [9:0] gap640;
  logic [9:0] next_gap640;

  always_comb
  begin
    next_gap640 = gap640 + 10'h001;
    if (sys_rst || master_ticks.div640 || !ring_osc_run)
    begin
      next_gap640 = '0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    gap640 <= next_gap640;
  end

  // programmable tick spacing, judged only while the divider value stood still
  logic [9:0]       ctrl_gap;
  logic [9:0]       next_ctrl_gap;
  logic             ctrl_gap_valid;
  logic             next_ctrl_gap_valid;
  logic [DIV_W-1:0] ctrl_div_q;
  logic [9:0]       host_gap;
  logic [9:0]       next_host_gap;
  logic             host_gap_valid;
  logic             next_host_gap_valid;
  logic [DIV_W-1:0] host_div_q;

  always_comb
  begin
    next_ctrl_gap       = ctrl_gap + 10'h001;
    next_ctrl_gap_valid = ctrl_gap_valid;
    next_host_gap       = host_gap + 10'h001;
    next_host_gap_valid = host_gap_valid;
    if (controller_bus_tick)
    begin
      next_ctrl_gap       = '0;
      next_ctrl_gap_valid = 1'b1;
    end
    if (host_bus_tick)
    begin
      next_host_gap       = '0;
      next_host_gap_valid = 1'b1;
    end
    if (sys_rst || !ring_osc_run || controller_div != ctrl_div_q)
    begin
      next_ctrl_gap_valid = 1'b0;
    end
    if (sys_rst || !ring_osc_run || host_div != host_div_q)
    begin
      next_host_gap_valid = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    ctrl_gap       <= next_ctrl_gap;
    ctrl_gap_valid <= next_ctrl_gap_valid;
    ctrl_div_q     <= controller_div;
    host_gap       <= next_host_gap;
    host_gap_valid <= next_host_gap_valid;
    host_div_q     <= host_div;
  end

  a_host_gated_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(runtime_supply_good) |-> !host_domain_div64_tick)
    else $error("host tick while runtime supply low");
  a_div2_period: assert property (@(posedge core_clk) disable iff (sys_rst)
    master_ticks.div2 && $past(ring_osc_run) && ring_osc_run ##1 ring_osc_run |-> ##1 master_ticks.div2)
    else $error("divide by two tick missing");
  a_div4_single: assert property (@(posedge core_clk) disable iff (sys_rst)
    master_ticks.div4 |=> !master_ticks.div4 [*3])
    else $error("divide by four tick too often");
  // first pulse after a restart trails the restart edge by two extra cycles
  a_div640_gap: assert property (@(posedge core_clk) disable iff (sys_rst)
    master_ticks.div640 |-> gap640 == cdd_pkg::RATIO_640 - 10'h001 || gap640 == cdd_pkg::RATIO_640 + 10'h002)
    else $error("divide by 640 spacing wrong");
  a_fixed_nested: assert property (@(posedge core_clk) disable iff (sys_rst)
    master_ticks.div640 |-> master_ticks.div128 && master_ticks.div64 && master_ticks.div32 &&
      master_ticks.div16 && master_ticks.div8 && master_ticks.div4 && master_ticks.div2)
    else $error("fixed ticks out of common phase");
  a_div8_nested: assert property (@(posedge core_clk) disable iff (sys_rst)
    master_ticks.div8 |-> master_ticks.div4 && master_ticks.div2)
    else $error("divide by eight tick off phase");
  a_osc_stop_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(ring_osc_run) |-> master_ticks == '0 && !controller_bus_tick)
    else $error("tick while oscillator stopped");
  a_host_osc_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(ring_osc_run) |-> !host_bus_tick && !host_domain_div64_tick)
    else $error("host tick while oscillator stopped");
  a_restart_phase: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(ring_osc_run) |-> !master_ticks.div2 ##1 !master_ticks.div2)
    else $error("tick too early after restart");
  a_ctrl_spacing: assert property (@(posedge core_clk) disable iff (sys_rst)
    controller_bus_tick && ctrl_gap_valid && controller_div == ctrl_div_q |->
      ctrl_gap == prog_ratio(controller_div) - 10'h001)
    else $error("controller tick spacing differs from divider");
  a_host_spacing: assert property (@(posedge core_clk) disable iff (sys_rst)
    host_bus_tick && host_gap_valid && host_div == host_div_q |->
      host_gap == prog_ratio(host_div) - 10'h001)
    else $error("host bus tick spacing differs from divider");
  a_host_div64_single: assert property (@(posedge core_clk) disable iff (sys_rst)
    host_domain_div64_tick |=> !host_domain_div64_tick [*8])
    else $error("host divide by 64 tick too often");
  a_raw_to_osc: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(sys_rst) |-> slow_fanout.ring_osc_raw == $past(slow_crystal_clock))
    else $error("oscillator copy not raw crystal");
  a_bypass_path: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(sys_rst) && $past(bypass) |-> slow_crystal_clock_synced == $past(slow_crystal_clock))
    else $error("bypass not honoured");
  a_sync_path: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(sys_rst) && !$past(sys_rst, 2) && !$past(sys_rst, 3) &&
      !$past(bypass) && !$past(bypass, 2) && !$past(bypass, 3) |->
      slow_crystal_clock_synced == $past(slow_crystal_clock, 3))
    else $error("synchronised clock latency wrong");
  a_fanout_same: assert property (@(posedge core_clk) disable iff (sys_rst)
    slow_fanout.week_timer == slow_crystal_clock_synced && slow_fanout.led_if == slow_crystal_clock_synced)
    else $error("slow fan-out differs");

  c_host_tick: cover property (@(posedge core_clk) host_domain_div64_tick);
  c_div640: cover property (@(posedge core_clk) master_ticks.div640);
  c_ctrl_tick: cover property (@(posedge core_clk) controller_bus_tick);
  c_bypass: cover property (@(posedge core_clk) bypass && slow_crystal_clock_synced);

endmodule : cdd_clock_dist

// ---- cdd_xtal_model.sv ----
// slow crystal stand-in: free-running square wave seen by the block
module cdd_xtal_model #(
  parameter int HALF = 13
) (
  // clock and crystal level
  input  wire logic core_clk,
  output logic      xtal
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial xtal = 1'b0;
  // never gated: the crystal keeps running in every power state
  always @(posedge core_clk)
  begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
      xtal <= ~xtal;
  end
endmodule : cdd_xtal_model

// ---- cdd_clock_dist_test.sv ----
// self-checking bench for the clock-domain distribution block
module cdd_clock_dist_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      core_clk = 1'b0;
  logic                      sys_rst = 1'b1;
  logic                      ring_osc_run = 1'b1;
  logic                      runtime_supply_good = 1'b1;
  logic                      standby_supply_good = 1'b1;
  logic [7:0]                controller_div = 8'h04;
  logic [7:0]                host_div = 8'h02;
  logic                      slow_crystal_clock;
  logic                      controller_bus_tick;
  logic                      host_bus_tick;
  logic                      host_domain_div64_tick;
  logic                      slow_crystal_clock_synced;
  cdd_pkg::cdd_fixed_ticks_t master_ticks;
  cdd_pkg::cdd_slow_fanout_t slow_fanout;
  logic [10:0]               tk;
  logic [2:0]                h = 3'h0;
  int                        errors = 0;
  int                        n_compared = 0;
  assign tk = {host_domain_div64_tick, host_bus_tick, controller_bus_tick, master_ticks};
  always #2 core_clk = ~core_clk;
  // crystal history, newest in bit 0
  always @(posedge core_clk) h <= {h[1:0], slow_crystal_clock};
  cdd_xtal_model i_cdd_xtal_model (.core_clk(core_clk), .xtal(slow_crystal_clock));
  cdd_clock_dist i_cdd_clock_dist (.core_clk, .sys_rst, .ring_osc_run, .runtime_supply_good,
    .standby_supply_good, .controller_div, .host_div, .slow_crystal_clock, .controller_bus_tick,
    .host_bus_tick, .master_ticks, .host_domain_div64_tick, .slow_crystal_clock_synced, .slow_fanout);

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  // cycles between two pulses of tick i
  task automatic per(input int i, input int n);
    int c;
    c = 0;
    while (tk[i] !== 1'b1 && c < 2000)
    begin
      @(negedge core_clk);
      c++;
    end
    c = 0;
    do
    begin
      @(negedge core_clk);
      c++;
    end
    while (tk[i] !== 1'b1 && c < 2000);
    chk($sformatf("period of tick %0d", i), c[15:0], n[15:0]);
  endtask : per

  task automatic quiet(input logic [10:0] mask, input int n);
    logic [10:0] acc;
    acc = 11'h000;
    repeat (n)
    begin
      @(negedge core_clk);
      acc = acc | (tk & mask);
    end
    chk("gated ticks", {5'h00, acc}, 16'h0000);
  endtask : quiet

  // lat is 3 through the synchroniser, 1 when bypassed
  task automatic sync(input int lat, input int n);
    repeat (n)
    begin
      @(negedge core_clk);
      chk("synced level", slow_crystal_clock_synced, (lat == 3) ? h[2] : h[0]);
      chk("raw copy", slow_fanout.ring_osc_raw, h[0]);
      chk("fanout", slow_fanout[5:0], {6{slow_crystal_clock_synced}});
    end
  endtask : sync

  task automatic t_fixed();
    int r[8] = '{2, 4, 8, 16, 32, 64, 128, 640};
    controller_div <= 8'h09;
    foreach (r[i])
      per(i, r[i]);
  endtask : t_fixed

  task automatic t_prog();
    @(posedge core_clk);
    controller_div <= 8'h05;
    host_div <= 8'h03;
    repeat (20) @(negedge core_clk);
    per(8, 5);
    per(9, 3);
    @(posedge core_clk);
    controller_div <= 8'h00;
    host_div <= 8'hff;
    repeat (600) @(negedge core_clk);
    per(8, 1);
    per(9, 255);
  endtask : t_prog

  task automatic t_host();
    @(posedge core_clk);
    runtime_supply_good <= 1'b0;
    repeat (3) @(negedge core_clk);
    quiet(11'h400, 200);
    per(5, 64);
    @(posedge core_clk);
    runtime_supply_good <= 1'b1;
    per(10, 64);
  endtask : t_host

  task automatic t_sync();
    repeat (4) @(negedge core_clk);
    sync(3, 80);
    @(posedge core_clk);
    standby_supply_good <= 1'b0;
    repeat (4) @(negedge core_clk);
    sync(1, 80);
    @(posedge core_clk);
    standby_supply_good <= 1'b1;
  endtask : t_sync

  task automatic t_osc();
    int c;
    @(posedge core_clk);
    ring_osc_run <= 1'b0;
    repeat (3) @(negedge core_clk);
    quiet(11'h7ff, 700);
    sync(1, 60);
    @(posedge core_clk);
    ring_osc_run <= 1'b1;
    c = 0;
    while (tk[1] !== 1'b1 && c < 50)
    begin
      @(negedge core_clk);
      c++;
    end
    chk("restart to first div4", {15'h0000, c > int'(cdd_pkg::RATIO_4) && c < 50}, 16'h0001);
  endtask : t_osc

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_fixed();
    t_prog();
    t_host();
    t_sync();
    t_osc();
    conclude();
  end

  // whole run needs well under 10000 cycles
  initial
  begin
    #100000;
    errors++;
    conclude();
  end
endmodule : cdd_clock_dist_test
